// ### mmc_handler.sv
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.svh"

module mmc_handler (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Configuration
  input  wire logic                slave_mode,
  input  wire logic [6:0]          own_dev_id,
  // Received byte stream
  input  wire mmc_pkg::mmc_byte_t  rx_byte,
  input  wire logic                rx_valid,
  // Front panel events
  input  wire logic                key_stop,
  input  wire logic                key_play,
  input  wire logic                key_ffwd,
  input  wire logic                key_rew,
  input  wire logic                shuttle_cue,
  input  wire logic                shuttle_review,
  input  wire logic                song_loaded,
  // Transport actions
  output logic                     xp_stop,
  output logic                     xp_play,
  output logic                     xp_ffwd,
  output logic                     xp_rew,
  output logic                     xp_record,
  output logic                     xp_punch_in,
  output logic                     xp_punch_out,
  output logic                     mmc_settings_reset,
  output mmc_pkg::mmc_xport_e      xport_state,
  // Transmit byte stream
  output mmc_pkg::mmc_byte_t       tx_byte,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output logic                     events_dropped
);
  import mmc_pkg::*;

  // ==========================================
  // Receive parser
  mmc_rx_e    rx_st_r, rx_st_nxt;
  logic       match_r, match_nxt;
  mmc_byte_t  cmd_r, cmd_nxt;
  logic       accept;

  always_comb begin
    rx_st_nxt = rx_st_r;
    match_nxt = match_r;
    cmd_nxt   = cmd_r;
    accept    = 1'b0;
    if (rx_valid) begin
      if (rx_byte == `MMC_SOX) begin
        rx_st_nxt = MMC_RX_UNIV;
      end else if (rx_byte[7] && rx_byte < 8'hF8) begin
        rx_st_nxt = MMC_RX_IDLE;
      end else if (!rx_byte[7] || rx_byte >= 8'hF8) begin
        if (rx_byte < 8'hF8) begin
          case (rx_st_r)
            MMC_RX_UNIV: begin
              rx_st_nxt = (rx_byte == `MMC_RT_UNIV) ? MMC_RX_DEV : MMC_RX_SKIP;
            end
            MMC_RX_DEV: begin
              match_nxt = (rx_byte[6:0] == own_dev_id) ||
                          (rx_byte[6:0] == `MMC_ALL_CALL);
              rx_st_nxt = MMC_RX_SUB;
            end
            MMC_RX_SUB: begin
              rx_st_nxt = (rx_byte == `MMC_SUB_MCC) ? MMC_RX_CMD : MMC_RX_SKIP;
            end
            MMC_RX_CMD: begin
              cmd_nxt   = rx_byte;
              rx_st_nxt = MMC_RX_EOX;
            end
            MMC_RX_EOX: begin
              rx_st_nxt = MMC_RX_SKIP;
            end
            MMC_RX_IDLE, MMC_RX_SKIP: begin
              rx_st_nxt = rx_st_r;
            end
            default: begin
              rx_st_nxt = MMC_RX_IDLE;
            end
          endcase
        end
      end
      if (rx_byte == `MMC_EOX && rx_st_r == MMC_RX_EOX) begin
        accept = match_r && slave_mode;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_st_r <= MMC_RX_IDLE;
      match_r <= 1'b0;
      cmd_r   <= '0;
    end else begin
      rx_st_r <= rx_st_nxt;
      match_r <= match_nxt;
      cmd_r   <= cmd_nxt;
    end
  end

  // ==========================================
  // Transport actions
  mmc_xport_e xs_r, xs_nxt;
  logic [7:0] act_nxt, act_r;

  always_comb begin
    xs_nxt  = xs_r;
    act_nxt = '0;
    if (accept) begin
      case (cmd_r)
        `MMC_CMD_STOP: begin
          act_nxt[0] = 1'b1;
          xs_nxt     = MMC_ST_STOPPED;
        end
        `MMC_CMD_PLAY, `MMC_CMD_DPLAY: begin
          act_nxt[1] = 1'b1;
          xs_nxt     = MMC_ST_PLAYING;
        end
        `MMC_CMD_FFWD: begin
          act_nxt[2] = 1'b1;
          xs_nxt     = MMC_ST_WINDING;
        end
        `MMC_CMD_REW: begin
          act_nxt[3] = 1'b1;
          xs_nxt     = MMC_ST_WINDING;
        end
        `MMC_CMD_RSTROBE: begin
          if (xs_r == MMC_ST_STOPPED) begin
            act_nxt[4] = 1'b1;
            xs_nxt     = MMC_ST_RECORDING;
          end else if (xs_r == MMC_ST_PLAYING) begin
            act_nxt[5] = 1'b1;
            xs_nxt     = MMC_ST_RECORDING;
          end
        end
        `MMC_CMD_REXIT: begin
          if (xs_r == MMC_ST_RECORDING) begin
            act_nxt[6] = 1'b1;
            xs_nxt     = MMC_ST_PLAYING;
          end
        end
        `MMC_CMD_RESET: begin
          act_nxt[7] = 1'b1;
        end
        default: begin
          act_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xs_r  <= MMC_ST_STOPPED;
      act_r <= '0;
    end else begin
      xs_r  <= xs_nxt;
      act_r <= act_nxt;
    end
  end

  assign xp_stop            = act_r[0];
  assign xp_play            = act_r[1];
  assign xp_ffwd            = act_r[2];
  assign xp_rew             = act_r[3];
  assign xp_record          = act_r[4];
  assign xp_punch_in        = act_r[5];
  assign xp_punch_out       = act_r[6];
  assign mmc_settings_reset = act_r[7];
  assign xport_state        = xs_r;

  // ==========================================
  // Transmit framer
  logic [4:0] pend_r, pend_nxt;
  logic [2:0] pos_r, pos_nxt;
  mmc_byte_t  tcmd_r, tcmd_nxt;
  logic       busy_r, busy_nxt;
  logic       drop_r, drop_nxt;
  mmc_byte_t  fb;
  logic       f_ready;
  logic [4:0] ev;

  always_comb begin
    ev = {song_loaded, key_rew | shuttle_review, key_ffwd | shuttle_cue,
          key_play, key_stop};
    pend_nxt = pend_r | ev;
    drop_nxt = |(pend_r & ev);
    pos_nxt  = pos_r;
    tcmd_nxt = tcmd_r;
    busy_nxt = busy_r;
    case (pos_r)
      3'd0: fb = `MMC_SOX;
      3'd1: fb = `MMC_RT_UNIV;
      3'd2: fb = {1'b0, `MMC_ALL_CALL};
      3'd3: fb = `MMC_SUB_MCC;
      3'd4: fb = tcmd_r;
      default: fb = `MMC_EOX;
    endcase
    if (busy_r) begin
      if (f_ready) begin
        pos_nxt  = pos_r + 3'd1;
        busy_nxt = (pos_r != `MMC_FRAME_LEN - 3'd1);
      end
    end else if (|pend_r) begin
      busy_nxt = 1'b1;
      pos_nxt  = '0;
      if (pend_r[0]) begin
        tcmd_nxt = `MMC_CMD_STOP;
        pend_nxt[0] = ev[0];
      end else if (pend_r[1]) begin
        tcmd_nxt = `MMC_CMD_DPLAY;
        pend_nxt[1] = ev[1];
      end else if (pend_r[2]) begin
        tcmd_nxt = `MMC_CMD_FFWD;
        pend_nxt[2] = ev[2];
      end else if (pend_r[3]) begin
        tcmd_nxt = `MMC_CMD_REW;
        pend_nxt[3] = ev[3];
      end else begin
        tcmd_nxt = `MMC_CMD_RESET;
        pend_nxt[4] = ev[4];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_r <= '0;
      pos_r  <= '0;
      tcmd_r <= '0;
      busy_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      pos_r  <= pos_nxt;
      tcmd_r <= tcmd_nxt;
      busy_r <= busy_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign events_dropped = drop_r;

  // Output queue; drain back-pressure stalls the framer
  mmc_fifo #(
    .WIDTH (8),
    .DEPTH (`MMC_FIFO_DEPTH),
    .AW    (`MMC_FIFO_AW)
  ) u_txq (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (fb),
    .in_valid  (busy_r),
    .in_ready  (f_ready),
    .out_data  (tx_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  // ==========================================
  // Checks
  property p_rx_stop;
    @(posedge clk_sys) disable iff (rst)
      (accept && cmd_r == `MMC_CMD_STOP) |=> xp_stop && xs_r == MMC_ST_STOPPED;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("stop not signalled");
  property p_rx_play;
    @(posedge clk_sys) disable iff (rst)
      (accept && (cmd_r == `MMC_CMD_PLAY || cmd_r == `MMC_CMD_DPLAY)) |=> xp_play;
  endproperty
  a_rx_play: assert property (p_rx_play) else $error("play not signalled");
  property p_rx_ffwd;
    @(posedge clk_sys) disable iff (rst)
      (accept && cmd_r == `MMC_CMD_FFWD) |=> xp_ffwd && !xp_rew;
  endproperty
  a_rx_ffwd: assert property (p_rx_ffwd) else $error("ffwd not signalled");
  property p_rx_rew;
    @(posedge clk_sys) disable iff (rst)
      (accept && cmd_r == `MMC_CMD_REW) |=> xp_rew && !xp_ffwd;
  endproperty
  a_rx_rew: assert property (p_rx_rew) else $error("rewind not signalled");
  property p_strobe_stopped;
    @(posedge clk_sys) disable iff (rst)
      (accept && cmd_r == `MMC_CMD_RSTROBE && xs_r == MMC_ST_STOPPED)
        |=> xp_record && xs_r == MMC_ST_RECORDING;
  endproperty
  a_strobe_stopped: assert property (p_strobe_stopped) else $error("no record");
  property p_strobe_play;
    @(posedge clk_sys) disable iff (rst)
      (accept && cmd_r == `MMC_CMD_RSTROBE && xs_r == MMC_ST_PLAYING) |=> xp_punch_in;
  endproperty
  a_strobe_play: assert property (p_strobe_play) else $error("no punch-in");
  property p_exit;
    @(posedge clk_sys) disable iff (rst)
      xp_punch_out |-> $past(xs_r) == MMC_ST_RECORDING;
  endproperty
  a_exit: assert property (p_exit) else $error("bad punch-out");
  property p_slave_only;
    @(posedge clk_sys) disable iff (rst)
      !$past(slave_mode) |-> act_r == '0;
  endproperty
  a_slave_only: assert property (p_slave_only) else $error("acted as master");
  property p_tx_stop;
    @(posedge clk_sys) disable iff (rst)
      (key_stop && !busy_r && pend_r == '0) |=> ##1 (busy_r && tcmd_r == `MMC_CMD_STOP);
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("stop frame not started");
  property p_tx_eox;
    @(posedge clk_sys) disable iff (rst)
      (busy_r && f_ready && pos_r == 3'd5) |=> !busy_r;
  endproperty
  a_tx_eox: assert property (p_tx_eox) else $error("frame not closed");
endmodule

`default_nettype wire

// ### mmc_consts.svh
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH

// ==========================================
// Frame bytes
`define MMC_SOX          8'hF0
`define MMC_RT_UNIV      8'h7F
`define MMC_ALL_CALL     7'h7F
`define MMC_SUB_MCC      8'h06
`define MMC_EOX          8'hF7

// ==========================================
// Command codes
`define MMC_CMD_STOP     8'h01
`define MMC_CMD_PLAY     8'h02
`define MMC_CMD_DPLAY    8'h03
`define MMC_CMD_FFWD     8'h04
`define MMC_CMD_REW      8'h05
`define MMC_CMD_RSTROBE  8'h06
`define MMC_CMD_REXIT    8'h07
`define MMC_CMD_RESET    8'h0D

// ==========================================
// Sizes
`define MMC_FRAME_LEN    3'd6
`define MMC_FIFO_DEPTH   16
`define MMC_FIFO_AW      4

`endif

// ### mmc_pkg.sv
`default_nettype none
`include "mmc_consts.svh"

package mmc_pkg;
  typedef logic [7:0] mmc_byte_t;
  typedef enum logic [1:0] {
    MMC_ST_STOPPED,
    MMC_ST_PLAYING,
    MMC_ST_RECORDING,
    MMC_ST_WINDING
  } mmc_xport_e;
  typedef enum {
    MMC_RX_IDLE,
    MMC_RX_UNIV,
    MMC_RX_DEV,
    MMC_RX_SUB,
    MMC_RX_CMD,
    MMC_RX_EOX,
    MMC_RX_SKIP
  } mmc_rx_e;
endpackage

`default_nettype wire

// ### mmc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.svh"

module mmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             vld_r, vld_nxt;
  logic             push, pop;

  // Head word and valid are registered so the drain side sees flops only
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = vld_r;
  assign out_data  = dout_r;
  assign push      = in_valid && in_ready;
  assign pop       = vld_r && out_ready;

  always_comb begin
    wp_nxt   = push ? wp_r + 1'b1 : wp_r;
    rp_nxt   = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    vld_nxt  = (cnt_nxt != '0);
    // A word written into the next head slot bypasses the array
    dout_nxt = (push && rp_nxt == wp_r) ? in_data : mem_r[rp_nxt];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      vld_r  <= 1'b0;
      dout_r <= '0;
    end else begin
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
      vld_r  <= vld_nxt;
      dout_r <= dout_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

`default_nettype wire

// ### mmc_midi_peer.sv
`timescale 1ns/10ps
`default_nettype none

module mmc_midi_peer (
  // Clock
  input  wire logic               clk_sys,
  // Bytes toward the handler
  output mmc_pkg::mmc_byte_t      rx_byte,
  output logic                    rx_valid,
  // Bytes from the handler
  input  wire mmc_pkg::mmc_byte_t tx_byte,
  input  wire logic               tx_valid,
  output logic                    tx_ready
);
  import mmc_pkg::*;

  mmc_byte_t got [$];
  logic      hold = 1'b0;
  logic      slow = 1'b0;
  logic      tgl  = 1'b0;

  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // ==========================================
  // Sink, optionally stalling or taking every other cycle
  always @(negedge clk_sys) begin
    tgl      <= ~tgl;
    tx_ready <= !hold && (!slow || tgl);
  end

  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_byte);
    end
  end

  // ==========================================
  // Source; an idle line shows the inverted last byte
  task automatic put(input mmc_byte_t b);
    @(negedge clk_sys);
    rx_byte  = b;
    rx_valid = 1'b1;
    @(negedge clk_sys);
    rx_byte  = ~b;
    rx_valid = 1'b0;
  endtask

  task automatic frame(input logic [47:0] f);
    for (int i = 5; i >= 0; i--) put(f[8*i +: 8]);
  endtask
endmodule

`default_nettype wire

// ### test_mmc_transport_command_handler.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end

module test_mmc_transport_command_handler;
  import mmc_pkg::*;

  logic       clk_sys    = 1'b0;
  logic       rst        = 1'b1;
  logic       slave_mode = 1'b1;
  logic [6:0] own_dev_id = 7'h05;
  logic [6:0] ev         = '0;
  wire  [8:0] act;
  logic [8:0] hits       = '0;
  logic       rx_valid, tx_valid, tx_ready;
  mmc_byte_t  rx_byte, tx_byte;
  mmc_xport_e xport_state;
  int         errors     = 0;
  int         n_tests    = 0;

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) hits <= hits | act;

  mmc_handler i_dut (
    .clk_sys(clk_sys), .rst(rst), .slave_mode(slave_mode), .own_dev_id(own_dev_id),
    .rx_byte(rx_byte), .rx_valid(rx_valid),
    .key_stop(ev[0]), .key_play(ev[1]), .key_ffwd(ev[2]), .key_rew(ev[3]),
    .shuttle_cue(ev[4]), .shuttle_review(ev[5]), .song_loaded(ev[6]),
    .xp_stop(act[0]), .xp_play(act[1]), .xp_ffwd(act[2]), .xp_rew(act[3]),
    .xp_record(act[4]), .xp_punch_in(act[5]), .xp_punch_out(act[6]),
    .mmc_settings_reset(act[7]), .xport_state(xport_state),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .events_dropped(act[8])
  );

  mmc_midi_peer i_peer (
    .clk_sys(clk_sys), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  // ==========================================
  // Helpers
  task automatic rx(input logic [47:0] f, input logic [8:0] e, input mmc_xport_e s);
    @(negedge clk_sys);
    hits = '0;
    i_peer.frame(f);
    repeat (4) @(negedge clk_sys);
    `CHK(hits, e)
    `CHK(xport_state, s)
  endtask

  task automatic chk_frame(input mmc_byte_t c);
    mmc_byte_t b;
    mmc_byte_t w [6];
    w = '{8'hF0, 8'h7F, 8'h7F, 8'h06, c, 8'hF7};
    for (int j = 0; j < 6; j++) begin
      b = i_peer.got.pop_front();
      `CHK(b, w[j])
    end
  endtask

  task automatic pulse(input int i);
    @(negedge clk_sys);
    ev[i] = 1'b1;
    @(negedge clk_sys);
    ev = '0;
    repeat (2) @(negedge clk_sys);
  endtask

  // ==========================================
  // Tests
  task automatic t_reset;
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    `CHK(xport_state, MMC_ST_STOPPED)
    `CHK(tx_valid, 1'b0)
    $display("t_reset done");
  endtask

  task automatic t_rx;
    rx(48'hF0_7F_05_06_02_F7, 9'h002, MMC_ST_PLAYING);
    rx(48'hF0_7F_7F_06_06_F7, 9'h020, MMC_ST_RECORDING);
    rx(48'hF0_7F_05_06_07_F7, 9'h040, MMC_ST_PLAYING);
    rx(48'hF0_7F_7F_06_01_F7, 9'h001, MMC_ST_STOPPED);
    rx(48'hF0_7F_05_06_07_F7, 9'h000, MMC_ST_STOPPED);
    rx(48'hF0_7F_05_06_06_F7, 9'h010, MMC_ST_RECORDING);
    rx(48'hF0_7F_05_06_01_F7, 9'h001, MMC_ST_STOPPED);
    rx(48'hF0_7F_7F_06_03_F7, 9'h002, MMC_ST_PLAYING);
    rx(48'hF0_7F_05_06_04_F7, 9'h004, MMC_ST_WINDING);
    rx(48'hF0_7F_7F_06_05_F7, 9'h008, MMC_ST_WINDING);
    rx(48'hF0_7F_05_06_0D_F7, 9'h080, MMC_ST_WINDING);
    $display("t_rx done");
  endtask

  task automatic t_refuse;
    mmc_byte_t rt [7];
    mmc_byte_t st [7];
    rt = '{8'hF0, 8'h7F, 8'h7F, 8'h06, 8'hF8, 8'h02, 8'hF7};
    st = '{8'hF0, 8'h7F, 8'h7E, 8'h90, 8'h06, 8'h01, 8'hF7};
    rx(48'hF0_7F_06_06_01_F7, 9'h000, MMC_ST_WINDING);
    slave_mode = 1'b0;
    rx(48'hF0_7F_05_06_01_F7, 9'h000, MMC_ST_WINDING);
    slave_mode = 1'b1;
    rx(48'hF0_7E_7F_06_01_F7, 9'h000, MMC_ST_WINDING);
    rx(48'hF0_7F_7F_05_01_F7, 9'h000, MMC_ST_WINDING);
    rx(48'hF0_7F_7F_06_08_F7, 9'h000, MMC_ST_WINDING);
    rx(48'hF0_7F_7F_06_01_00, 9'h000, MMC_ST_WINDING);
    own_dev_id = 7'h7E;
    rx(48'hF0_7F_7E_06_01_F7, 9'h001, MMC_ST_STOPPED);
    @(negedge clk_sys);
    hits = '0;
    foreach (st[i]) i_peer.put(st[i]);
    repeat (4) @(negedge clk_sys);
    `CHK(hits, 9'h000)
    i_peer.put(8'hF0);
    i_peer.put(8'h7F);
    rx(48'hF0_7F_7F_06_05_F7, 9'h008, MMC_ST_WINDING);
    @(negedge clk_sys);
    hits = '0;
    foreach (rt[i]) i_peer.put(rt[i]);
    repeat (4) @(negedge clk_sys);
    `CHK(hits, 9'h002)
    $display("t_refuse done");
  endtask

  task automatic t_tx;
    mmc_byte_t code [7];
    code = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h04, 8'h05, 8'h0D};
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      for (int k = 0; k < 60 && i_peer.got.size() < 6; k++) @(negedge clk_sys);
      `CHK(i_peer.got.size(), 6)
      chk_frame(code[i]);
    end
    $display("t_tx done");
  endtask

  task automatic t_fifo;
    i_peer.hold = 1'b1;
    hits        = '0;
    pulse(0);
    pulse(1);
    pulse(2);
    pulse(3);
    pulse(3);
    repeat (40) @(negedge clk_sys);
    `CHK(tx_valid, 1'b1)
    `CHK(i_peer.got.size(), 0)
    `CHK(hits[8], 1'b1)
    i_peer.slow = 1'b1;
    i_peer.hold = 1'b0;
    for (int k = 0; k < 300 && i_peer.got.size() < 24; k++) @(negedge clk_sys);
    repeat (20) @(negedge clk_sys);
    `CHK(i_peer.got.size(), 24)
    chk_frame(8'h01);
    chk_frame(8'h03);
    chk_frame(8'h04);
    chk_frame(8'h05);
    `CHK(tx_valid, 1'b0)
    $display("t_fifo done");
  endtask

  // ==========================================
  // Verdict
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    errors++;
    report_and_stop;
  end

  initial begin
    t_reset;
    t_rx;
    t_refuse;
    t_tx;
    t_fifo;
    t_reset;
    report_and_stop;
  end
endmodule

`default_nettype wire
